/* hw/pif_pkg.sv */
package pif_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] PIF_OFS_FLAGS_ONE = 8'h00;
  localparam logic [7:0] PIF_OFS_FLAGS_TWO = 8'h04;
  localparam logic [7:0] PIF_OFS_ENABLES_ONE = 8'h08;
  localparam logic [7:0] PIF_OFS_ENABLES_TWO = 8'h0c;
  localparam logic [7:0] PIF_OFS_PRIORITY_ONE = 8'h10;
  localparam logic [7:0] PIF_OFS_PRIORITY_TWO = 8'h14;
  localparam logic [7:0] PIF_OFS_CONTROL = 8'h18;
  localparam logic [7:0] PIF_OFS_STATUS = 8'h1c;
  // reset values
  localparam logic [7:0] PIF_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIF_RST_ENABLES = 8'h00;
  localparam logic [7:0] PIF_RST_PRIORITY = 8'hff;
  // first-register bit positions
  localparam int PIF_B1_TIMER_ONE = 0;
  localparam int PIF_B1_TIMER_TWO = 1;
  localparam int PIF_B1_CC1 = 2;
  localparam int PIF_B1_SSP = 3;
  localparam int PIF_B1_TX = 4;
  localparam int PIF_B1_RX = 5;
  localparam int PIF_B1_ADC = 6;
  localparam int PIF_B1_PAR = 7;
  // second-register bit positions
  localparam int PIF_B2_CC2 = 0;
  localparam int PIF_B2_TIMER_THREE = 1;
  localparam int PIF_B2_VDET = 2;
  localparam int PIF_B2_BCOL = 3;
  localparam int PIF_B2_NVW = 4;
  localparam int PIF_B2_CMP2 = 5;
  localparam int PIF_B2_CMP1 = 6;
  localparam int PIF_B2_OSCF = 7;
  // control register fields
  localparam int PIF_CTL_PRIO_EN = 0;
  localparam int PIF_CTL_GROUP_EN = 1;
  // capture/compare unit modes
  typedef enum logic [1:0] {PIF_CC_OFF, PIF_CC_CAPTURE, PIF_CC_COMPARE, PIF_CC_PWM} pif_cc_mode_t;
  // peripheral event pulses, one cycle each
  typedef struct packed {
    logic timer_one_ovf;
    logic timer_two_match;
    logic timer_three_ovf;
    logic cc1_capture;
    logic cc1_compare;
    logic cc2_capture;
    logic cc2_compare;
    logic ssp_done;
    logic adc_done;
    logic par_access;
    logic osc_fail;
    logic bus_collision;
    logic voltage_detect;
    logic nv_write_done;
  } pif_events_t;
  // serial flag levels driven by the serial unit itself
  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } pif_serial_t;
endpackage

/* hw/pif_top.sv */
`timescale 1ns/1ps
// How it works
// - capture event sets capcomp flag, software clears
// - compare match sets flag; PWM mode ignored
// - timer two period match sets bit one
// - timer one overflow sets bit zero
// - 28-pin: parallel bit seven reads zero
// - oscillator failure sets second-register bit seven
// - comparator output change sets bit six/five
// - nonvolatile write completion sets bit four
// - bus collision sets bit three
// - voltage detect event sets bit two
// - timer three overflow sets bit one
// - flags sticky until written zero; reset zero
// - no priority: group enable gates all requests
// - enable bit gates same-position flag; reset zero
// - priority bits used only with priority enabled
// - priority bit one high, zero low; reset one
// - flags set regardless of any enable
// - with priority: group enable gates low requests
// - serial flags follow buffer state, not software
module pif_top import pif_pkg::*; #(
  parameter bit PINS_28 = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pif_events_t events,
  input wire pif_serial_t serial,
  input wire pif_cc_mode_t cc1_mode,
  input wire pif_cc_mode_t cc2_mode,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  output logic irq_high,
  output logic irq_low
);
  // register state
  logic [7:0] flags_one_ff; // serial bits unused here, they come from the serial unit
  logic [7:0] periph_flags_two_ff;
  logic [7:0] periph_enables_one_ff;
  logic [7:0] periph_enables_two_ff;
  logic [7:0] periph_priority_one_ff;
  logic [7:0] periph_priority_two_ff;
  logic [1:0] ctl_ff; // priority levels enable, group enable
  // bus data-phase bookkeeping
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic cmp1_d_ff;
  logic cmp2_d_ff;
  logic irq_high_ff;
  logic irq_low_ff;
  // combinational helpers
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] flags_one_view;
  logic [7:0] impl_mask_one;
  logic [7:0] pend_one;
  logic [7:0] pend_two;
  logic nxt_irq_high;
  logic nxt_irq_low;
  logic addr_phase;
  logic wr_one;
  logic wr_two;

  // clear mask for unimplemented parallel port bit
  assign impl_mask_one = PINS_28 ? 8'h7f : 8'hff;

  // single-bit write helper: true when the pending data-phase write targets byte address a
  function automatic logic wr_hit(input logic [7:0] a);
    return wr_pend_ff && (wr_addr_ff == a);
  endfunction

  assign addr_phase = hsel && hready && htrans[1];
  assign wr_one = wr_hit(PIF_OFS_FLAGS_ONE);
  assign wr_two = wr_hit(PIF_OFS_FLAGS_TWO);

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // comparator output history for change detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp1_d_ff <= 1'b0;
      cmp2_d_ff <= 1'b0;
    end else begin
      cmp1_d_ff <= cmp1_out;
      cmp2_d_ff <= cmp2_out;
    end
  end

  // event set vectors, independent of enables
  always_comb begin
    set_one = 8'h00;
    set_two = 8'h00;
    set_one[PIF_B1_TIMER_ONE] = events.timer_one_ovf;
    set_one[PIF_B1_TIMER_TWO] = events.timer_two_match;
    // capture or compare per mode; pwm leaves the flag alone
    set_one[PIF_B1_CC1] = (cc1_mode == PIF_CC_CAPTURE && events.cc1_capture)
      || (cc1_mode == PIF_CC_COMPARE && events.cc1_compare);
    set_one[PIF_B1_SSP] = events.ssp_done;
    set_one[PIF_B1_ADC] = events.adc_done;
    set_one[PIF_B1_PAR] = events.par_access && !PINS_28;
    set_two[PIF_B2_CC2] = (cc2_mode == PIF_CC_CAPTURE && events.cc2_capture)
      || (cc2_mode == PIF_CC_COMPARE && events.cc2_compare);
    set_two[PIF_B2_TIMER_THREE] = events.timer_three_ovf;
    set_two[PIF_B2_VDET] = events.voltage_detect;
    set_two[PIF_B2_BCOL] = events.bus_collision;
    set_two[PIF_B2_NVW] = events.nv_write_done;
    set_two[PIF_B2_CMP2] = cmp2_out ^ cmp2_d_ff;
    set_two[PIF_B2_CMP1] = cmp1_out ^ cmp1_d_ff;
    set_two[PIF_B2_OSCF] = events.osc_fail;
  end

  // first flag register: sticky, set beats a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_one_ff <= PIF_RST_FLAGS;
    end else if (wr_one) begin
      flags_one_ff <= ((hwdata[7:0] & impl_mask_one) | set_one);
    end else begin
      flags_one_ff <= flags_one_ff | set_one;
    end
  end

  // second flag register, same policy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_flags_two_ff <= PIF_RST_FLAGS;
    end else if (wr_two) begin
      periph_flags_two_ff <= hwdata[7:0] | set_two;
    end else begin
      periph_flags_two_ff <= periph_flags_two_ff | set_two;
    end
  end

  // serial bits mirror the serial unit and ignore software writes
  always_comb begin
    flags_one_view = flags_one_ff & impl_mask_one;
    flags_one_view[PIF_B1_RX] = serial.rx_full;
    flags_one_view[PIF_B1_TX] = serial.tx_empty;
  end

  // enable and priority registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_enables_one_ff <= PIF_RST_ENABLES;
      periph_enables_two_ff <= PIF_RST_ENABLES;
      periph_priority_one_ff <= PIF_RST_PRIORITY;
      periph_priority_two_ff <= PIF_RST_PRIORITY;
      ctl_ff <= 2'h0;
    end else begin
      if (wr_hit(PIF_OFS_ENABLES_ONE)) periph_enables_one_ff <= hwdata[7:0] & impl_mask_one;
      if (wr_hit(PIF_OFS_ENABLES_TWO)) periph_enables_two_ff <= hwdata[7:0];
      if (wr_hit(PIF_OFS_PRIORITY_ONE)) periph_priority_one_ff <= hwdata[7:0] & impl_mask_one;
      if (wr_hit(PIF_OFS_PRIORITY_TWO)) periph_priority_two_ff <= hwdata[7:0];
      if (wr_hit(PIF_OFS_CONTROL)) ctl_ff <= hwdata[1:0];
    end
  end

  // read data registered in address phase, shown in data phase
  // limitation: a read whose address phase overlaps a write's data phase
  // to the same register returns the value from before that write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        PIF_OFS_FLAGS_ONE: hrdata_ff <= {24'h0, flags_one_view};
        PIF_OFS_FLAGS_TWO: hrdata_ff <= {24'h0, periph_flags_two_ff};
        PIF_OFS_ENABLES_ONE: hrdata_ff <= {24'h0, periph_enables_one_ff};
        PIF_OFS_ENABLES_TWO: hrdata_ff <= {24'h0, periph_enables_two_ff};
        PIF_OFS_PRIORITY_ONE: hrdata_ff <= {24'h0, periph_priority_one_ff & impl_mask_one};
        PIF_OFS_PRIORITY_TWO: hrdata_ff <= {24'h0, periph_priority_two_ff};
        PIF_OFS_CONTROL: hrdata_ff <= {30'h0, ctl_ff};
        PIF_OFS_STATUS: hrdata_ff <= {30'h0, irq_low_ff, irq_high_ff};
        default: hrdata_ff <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // request combination
  always_comb begin
    pend_one = flags_one_view & periph_enables_one_ff;
    pend_two = periph_flags_two_ff & periph_enables_two_ff;
    if (ctl_ff[PIF_CTL_PRIO_EN]) begin
      // priority routing active
      nxt_irq_high = |(pend_one & periph_priority_one_ff)
        || |(pend_two & periph_priority_two_ff);
      nxt_irq_low = ctl_ff[PIF_CTL_GROUP_EN] && (|(pend_one & ~periph_priority_one_ff)
        || |(pend_two & ~periph_priority_two_ff));
    end else begin
      // compatibility mode: one request, gated by group enable
      nxt_irq_high = ctl_ff[PIF_CTL_GROUP_EN] && (|pend_one || |pend_two);
      nxt_irq_low = 1'b0;
    end
  end

  // requests come from flip-flops, one cycle after the cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_high_ff <= 1'b0;
      irq_low_ff <= 1'b0;
    end else begin
      irq_high_ff <= nxt_irq_high;
      irq_low_ff <= nxt_irq_low;
    end
  end
  assign irq_high = irq_high_ff;
  assign irq_low = irq_low_ff;

  // assertions
  property p_timer_one_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.timer_one_ovf |=> flags_one_ff[PIF_B1_TIMER_ONE];
  endproperty
  a_timer_one_sets: assert property (p_timer_one_sets) else $error("timer one flag not set");
  property p_timer_three_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.timer_three_ovf |=> periph_flags_two_ff[PIF_B2_TIMER_THREE];
  endproperty
  a_timer_three_sets: assert property (p_timer_three_sets) else $error("timer three flag not set");
  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
      periph_flags_two_ff[PIF_B2_BCOL] && !wr_two |=> periph_flags_two_ff[PIF_B2_BCOL];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without write");
  property p_pwm_ignored;
    @(posedge hclk) disable iff (!hresetn)
      cc1_mode == PIF_CC_PWM && !flags_one_ff[PIF_B1_CC1] && !wr_one |=> !flags_one_ff[PIF_B1_CC1];
  endproperty
  a_pwm_ignored: assert property (p_pwm_ignored) else $error("pwm set capcomp flag");
  property p_cmp_change;
    @(posedge hclk) disable iff (!hresetn) $changed(cmp1_d_ff) |-> periph_flags_two_ff[PIF_B2_CMP1];
  endproperty
  a_cmp_change: assert property (p_cmp_change) else $error("comparator change missed");
  property p_no_group;
    @(posedge hclk) disable iff (!hresetn)
      !ctl_ff[PIF_CTL_PRIO_EN] && !ctl_ff[PIF_CTL_GROUP_EN] |=> !irq_high;
  endproperty
  a_no_group: assert property (p_no_group) else $error("request without group enable");
  property p_low_gate;
    @(posedge hclk) disable iff (!hresetn) !ctl_ff[PIF_CTL_GROUP_EN] |=> !irq_low;
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low request without enable");
  property p_high_req;
    @(posedge hclk) disable iff (!hresetn)
      ctl_ff[PIF_CTL_PRIO_EN] && |(pend_two & periph_priority_two_ff) |=> irq_high;
  endproperty
  a_high_req: assert property (p_high_req) else $error("high request missing");
  property p_par_zero;
    @(posedge hclk) disable iff (!hresetn) PINS_28 |-> !flags_one_view[PIF_B1_PAR];
  endproperty
  a_par_zero: assert property (p_par_zero) else $error("parallel bit visible");
  // period match of timer two lands in bit one
  property p_timer_two_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.timer_two_match |=> flags_one_ff[PIF_B1_TIMER_TWO];
  endproperty
  a_timer_two_sets: assert property (p_timer_two_sets) else $error("timer two flag not set");
  // capture only counts while the unit is in capture mode
  property p_capture_sets;
    @(posedge hclk) disable iff (!hresetn)
      cc1_mode == PIF_CC_CAPTURE && events.cc1_capture |=> flags_one_ff[PIF_B1_CC1];
  endproperty
  a_capture_sets: assert property (p_capture_sets) else $error("capture flag not set");
  // compare match only counts while the unit is in compare mode
  property p_compare_sets;
    @(posedge hclk) disable iff (!hresetn)
      cc2_mode == PIF_CC_COMPARE && events.cc2_compare |=> periph_flags_two_ff[PIF_B2_CC2];
  endproperty
  a_compare_sets: assert property (p_compare_sets) else $error("compare flag not set");
  // clock failure flag
  property p_osc_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.osc_fail |=> periph_flags_two_ff[PIF_B2_OSCF];
  endproperty
  a_osc_sets: assert property (p_osc_sets) else $error("oscillator flag not set");
  // second comparator change, same scheme as the first
  property p_cmp2_change;
    @(posedge hclk) disable iff (!hresetn)
      $changed(cmp2_d_ff) |-> periph_flags_two_ff[PIF_B2_CMP2];
  endproperty
  a_cmp2_change: assert property (p_cmp2_change) else $error("comparator two change missed");
  // nonvolatile write completion
  property p_nv_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.nv_write_done |=> periph_flags_two_ff[PIF_B2_NVW];
  endproperty
  a_nv_sets: assert property (p_nv_sets) else $error("write done flag not set");
  // bus collision
  property p_bcol_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.bus_collision |=> periph_flags_two_ff[PIF_B2_BCOL];
  endproperty
  a_bcol_sets: assert property (p_bcol_sets) else $error("collision flag not set");
  // voltage detector report
  property p_vdet_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.voltage_detect |=> periph_flags_two_ff[PIF_B2_VDET];
  endproperty
  a_vdet_sets: assert property (p_vdet_sets) else $error("voltage flag not set");
  // polling works with every enable off
  property p_poll_sets;
    @(posedge hclk) disable iff (!hresetn)
      events.adc_done |=> flags_one_ff[PIF_B1_ADC];
  endproperty
  a_poll_sets: assert property (p_poll_sets) else $error("polled flag not set");
  // a zero write clears a flag when no event races it
  property p_write_clears;
    @(posedge hclk) disable iff (!hresetn)
      wr_two && !hwdata[PIF_B2_BCOL] && !set_two[PIF_B2_BCOL] |=> !periph_flags_two_ff[PIF_B2_BCOL];
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("flag not cleared");
  // nothing pending means no request at all
  property p_enable_gate;
    @(posedge hclk) disable iff (!hresetn)
      pend_one == 8'h00 && pend_two == 8'h00 |=> !irq_high && !irq_low;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("request without enable");
  // compatibility mode with group enable raises the single request
  property p_compat_high;
    @(posedge hclk) disable iff (!hresetn)
      !ctl_ff[PIF_CTL_PRIO_EN] && ctl_ff[PIF_CTL_GROUP_EN] && (|pend_one || |pend_two) |=> irq_high;
  endproperty
  a_compat_high: assert property (p_compat_high) else $error("compat request missing");
  // priority bits are ignored without priority levels
  property p_prio_low_off;
    @(posedge hclk) disable iff (!hresetn) !ctl_ff[PIF_CTL_PRIO_EN] |=> !irq_low;
  endproperty
  a_prio_low_off: assert property (p_prio_low_off) else $error("low request in compat mode");
  // priority bit one routes a pending source high
  property p_prio_high_one;
    @(posedge hclk) disable iff (!hresetn)
      ctl_ff[PIF_CTL_PRIO_EN] && |(pend_one & periph_priority_one_ff) |=> irq_high;
  endproperty
  a_prio_high_one: assert property (p_prio_high_one) else $error("high routing missing");
  // priority bit zero routes a pending source low
  property p_low_req;
    @(posedge hclk) disable iff (!hresetn)
      ctl_ff[PIF_CTL_PRIO_EN] && ctl_ff[PIF_CTL_GROUP_EN] && |(pend_one & ~periph_priority_one_ff) |=> irq_low;
  endproperty
  a_low_req: assert property (p_low_req) else $error("low request missing");
  // serial bits always show the serial unit's levels
  property p_serial_view;
    @(posedge hclk) disable iff (!hresetn)
      flags_one_view[PIF_B1_RX] == serial.rx_full && flags_one_view[PIF_B1_TX] == serial.tx_empty;
  endproperty
  a_serial_view: assert property (p_serial_view) else $error("serial flag not mirrored");
  // parallel enable cannot be stored on the small package
  property p_par_enable;
    @(posedge hclk) disable iff (!hresetn)
      PINS_28 |-> !periph_enables_one_ff[PIF_B1_PAR];
  endproperty
  a_par_enable: assert property (p_par_enable) else $error("parallel enable stored");
  c_high: cover property (@(posedge hclk) disable iff (!hresetn) irq_high);
  c_low: cover property (@(posedge hclk) disable iff (!hresetn) irq_low);
  c_clear: cover property (@(posedge hclk) disable iff (!hresetn) wr_two && |set_two);
  c_compat: cover property (@(posedge hclk) disable iff (!hresetn) irq_high && !ctl_ff[0]);
  c_cmp: cover property (@(posedge hclk) disable iff (!hresetn) set_two[PIF_B2_CMP1]);
endmodule // pif_top

/* test/pif_event_source.sv */
`timescale 1ns/1ps
// peripheral sources: every event is a single-cycle pulse
module pif_event_source import pif_pkg::*; (
  input wire logic hclk,
  output pif_events_t events
);
  // quiet until a pulse is asked for
  initial events = '0;
  // launch after an edge, drop after the next, so the block sees it exactly once
  task automatic pulse(input pif_events_t ev);
    @(posedge hclk);
    events <= ev;
    @(posedge hclk);
    events <= '0;
  endtask
endmodule // pif_event_source

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench import pif_pkg::*; ;
  typedef struct packed {logic [7:0] a, rst, wv, rb;} pif_reg_row_t;
  typedef struct packed {
    pif_events_t ev;
    pif_cc_mode_t m;
    logic [1:0] cmp; // cmp1 high bit, cmp2 low bit
    logic [7:0] f1, f2;
  } pif_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, cmp1_out, cmp2_out, irq_high, irq_low;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  pif_events_t events;
  pif_serial_t serial;
  pif_cc_mode_t cc1_mode, cc2_mode;
  int fails, check_count;
  pif_reg_row_t regs[9];
  pif_row_t rows[18];
  // 200 MHz
  always #2.5 hclk = ~hclk;
  // 28-pin build so the parallel bit must read zero
  pif_top #(.PINS_28(1'b1)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .events(events), .serial(serial), .cc1_mode(cc1_mode), .cc2_mode(cc2_mode),
    .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .irq_high(irq_high), .irq_low(irq_low));
  pif_event_source i_src (.hclk(hclk), .events(events));
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask
  // one single word transfer; only the low byte matters to the block
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // irq settles a couple of edges after the cause
  task automatic chk_irq(input logic h, input logic l);
    repeat (3) @(posedge hclk);
    chk("irq_high", {31'h0, h}, {31'h0, irq_high});
    chk("irq_low", {31'h0, l}, {31'h0, irq_low});
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    print_verdict();
  end
  initial begin
    hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
    serial = '0; cc1_mode = PIF_CC_OFF; cc2_mode = PIF_CC_OFF;
    cmp1_out = 1'b0; cmp2_out = 1'b0; fails = 0; check_count = 0;
    // address, reset value, written value, value read back
    regs[0] = '{8'h08, 8'h00, 8'hff, 8'h7f};
    regs[1] = '{8'h0c, 8'h00, 8'ha5, 8'ha5};
    regs[2] = '{8'h10, 8'h7f, 8'h00, 8'h00};
    regs[3] = '{8'h14, 8'hff, 8'h5a, 8'h5a};
    regs[4] = '{8'h18, 8'h00, 8'h00, 8'h00};
    regs[5] = '{8'h1c, 8'h00, 8'hff, 8'h00};
    regs[6] = '{8'h20, 8'h00, 8'hff, 8'h00};
    regs[7] = '{8'h00, 8'h00, 8'h00, 8'h00};
    regs[8] = '{8'h04, 8'h00, 8'h00, 8'h00};
    // event pulse, unit mode, comparator levels, expected flags one and two
    rows[0] = '{14'h2000, PIF_CC_OFF, 2'b00, 8'h01, 8'h00};
    rows[1] = '{14'h1000, PIF_CC_OFF, 2'b00, 8'h02, 8'h00};
    rows[2] = '{14'h0400, PIF_CC_CAPTURE, 2'b00, 8'h04, 8'h00};
    rows[3] = '{14'h0200, PIF_CC_COMPARE, 2'b00, 8'h04, 8'h00};
    rows[4] = '{14'h0200, PIF_CC_PWM, 2'b00, 8'h00, 8'h00};
    rows[5] = '{14'h0100, PIF_CC_CAPTURE, 2'b00, 8'h00, 8'h01};
    rows[6] = '{14'h0080, PIF_CC_COMPARE, 2'b00, 8'h00, 8'h01};
    rows[7] = '{14'h0080, PIF_CC_PWM, 2'b00, 8'h00, 8'h00};
    rows[8] = '{14'h0800, PIF_CC_OFF, 2'b00, 8'h00, 8'h02};
    rows[9] = '{14'h0002, PIF_CC_OFF, 2'b00, 8'h00, 8'h04};
    rows[10] = '{14'h0004, PIF_CC_OFF, 2'b00, 8'h00, 8'h08};
    rows[11] = '{14'h0001, PIF_CC_OFF, 2'b00, 8'h00, 8'h10};
    rows[12] = '{14'h0008, PIF_CC_OFF, 2'b00, 8'h00, 8'h80};
    rows[13] = '{14'h0010, PIF_CC_OFF, 2'b00, 8'h00, 8'h00};
    rows[14] = '{14'h0060, PIF_CC_OFF, 2'b00, 8'h48, 8'h00};
    rows[15] = '{14'h0000, PIF_CC_OFF, 2'b01, 8'h00, 8'h20};
    rows[16] = '{14'h0000, PIF_CC_OFF, 2'b11, 8'h00, 8'h40};
    rows[17] = '{14'h0000, PIF_CC_OFF, 2'b10, 8'h00, 8'h20};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_irq(1'b0, 1'b0);
    foreach (regs[i]) begin
      rd(regs[i].a, "reset value", regs[i].rst);
      wr(regs[i].a, regs[i].wv);
      rd(regs[i].a, "read back", regs[i].rb);
    end
    // clear both flag registers, then one cause per row, two (ssp and adc) in row 14
    foreach (rows[i]) begin
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      cc1_mode <= rows[i].m;
      cc2_mode <= rows[i].m;
      cmp1_out <= rows[i].cmp[1];
      cmp2_out <= rows[i].cmp[0];
      i_src.pulse(rows[i].ev);
      repeat (2) @(posedge hclk);
      rd(8'h00, "flags one", rows[i].f1);
      rd(8'h04, "flags two", rows[i].f2);
    end
    // routing of one sticky flag through enable, group enable and priority
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h01);
    i_src.pulse(14'h2000);
    repeat (20) @(posedge hclk);
    rd(8'h00, "sticky flag", 8'h01);
    chk_irq(1'b0, 1'b0);
    wr(8'h18, 8'h02);
    chk_irq(1'b1, 1'b0);
    wr(8'h18, 8'h03);
    chk_irq(1'b0, 1'b1);
    wr(8'h18, 8'h01);
    chk_irq(1'b0, 1'b0);
    wr(8'h10, 8'h01);
    chk_irq(1'b1, 1'b0);
    rd(8'h1c, "status", 8'h01);
    wr(8'h08, 8'h00);
    chk_irq(1'b0, 1'b0);
    wr(8'h00, 8'h00);
    rd(8'h00, "flag cleared", 8'h00);
    // receive level is not cleared by a software write
    serial <= '{rx_full: 1'b1, tx_empty: 1'b0};
    repeat (2) @(posedge hclk);
    wr(8'h00, 8'h00);
    rd(8'h00, "receive flag", 8'h20);
    serial <= '0;
    repeat (2) @(posedge hclk);
    rd(8'h00, "receive flag gone", 8'h00);
    // reset in mid-run wipes a set flag and restores priorities and control; enable one was already zero before it, enable two still held a5
    i_src.pulse(14'h2000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, "flags after reset", 8'h00);
    rd(8'h08, "enables after reset", 8'h00);
    rd(8'h10, "priority after reset", 8'h7f);
    rd(8'h18, "control after reset", 8'h00);
    print_verdict();
  end
endmodule // testbench
